// ---- media_model.sv ----
// behavioural disk medium that takes words and can fail one sector
module media_model
    import msw_pkg::*;
(
    // clock and reset
    input wire logic                clk_i,
    input wire logic                rst_i,
    // word port
    input wire msw_pkg::media_req_t media_i,
    output logic                    ready_o,
    output logic                    error_o,
    // scenario control
    input wire logic                slow_i,
    input wire logic                fail_en_i,
    input wire logic [47:0]         fail_lba_i
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [1:0]  slot_q = 2'h0;
    logic        tgl_q = 1'b0;
    logic [15:0] words_q[$];
    logic [47:0] lba_q[$];
    // slow mode takes one word in four cycles to stall the block
    assign ready_o = media_i.valid && (!slow_i || slot_q == 2'h3);
    // error only means something on the final word; otherwise a moving pattern
    assign error_o = (media_i.valid && media_i.last) ? (fail_en_i && media_i.lba == fail_lba_i) : tgl_q;
    always @(posedge clk_i) begin
        slot_q <= slot_q + 2'h1;
        tgl_q  <= !tgl_q;
        if (rst_i) begin
            words_q.delete();
            lba_q.delete();
        end else if (ready_o) begin
            words_q.push_back(media_i.data);
            if (media_i.last) lba_q.push_back(media_i.lba);
        end
    end
endmodule : media_model

// ---- msw_pkg.sv ----
// constants, states and carriers for the block-mode multi-sector write interpreter
package msw_pkg;

    // ======================================================================
    // opcodes
    localparam logic [7:0] OP_WRITE_BLOCK     = 8'hC5;
    localparam logic [7:0] OP_WRITE_BLOCK_EXT = 8'h39;

    // ======================================================================
    // wishbone byte offsets
    localparam logic [7:0] OFF_DATA      = 8'h00;
    localparam logic [7:0] OFF_COUNT     = 8'h04;
    localparam logic [7:0] OFF_SECTOR    = 8'h08;
    localparam logic [7:0] OFF_CYL_LOW   = 8'h0C;
    localparam logic [7:0] OFF_CYL_HIGH  = 8'h10;
    localparam logic [7:0] OFF_DRV_HEAD  = 8'h14;
    localparam logic [7:0] OFF_CMD_STAT  = 8'h18;
    localparam logic [7:0] OFF_ERROR     = 8'h1C;
    localparam logic [7:0] OFF_IRQ_STAT  = 8'h20;
    localparam logic [7:0] OFF_IRQ_MASK  = 8'h24;
    localparam logic [7:0] OFF_CTRL      = 8'h28;

    // ======================================================================
    // field positions
    localparam int unsigned BUSY_BIT       = 7;
    localparam int unsigned READY_BIT      = 6;
    localparam int unsigned FAULT_BIT      = 5;
    localparam int unsigned SEEK_BIT       = 4;
    localparam int unsigned DRQ_BIT        = 3;
    localparam int unsigned CORR_BIT       = 2;
    localparam int unsigned STAT_ERR_BIT   = 0;
    localparam int unsigned IDNF_BIT       = 4;
    localparam int unsigned ABORT_BIT      = 2;
    localparam int unsigned DH_LBA_BIT     = 6;
    localparam int unsigned CTRL_HOB_BIT   = 8;
    localparam int unsigned IRQ_BLOCK_BIT  = 0;
    localparam int unsigned IRQ_DONE_BIT   = 1;

    // ======================================================================
    // reset values and count limits
    localparam logic [7:0]  STAT_RESET     = 8'h50;
    localparam logic [7:0]  BLK_RESET      = 8'h01;
    localparam logic [16:0] CNT28_ZERO     = 17'h00100;
    localparam logic [16:0] CNT48_ZERO     = 17'h10000;

    // ======================================================================
    // types
    typedef enum logic [1:0] {
        ST_IDLE   = 2'b00,
        ST_XFER   = 2'b01,
        ST_COMMIT = 2'b10
    } phase_t;

    typedef struct packed {
        logic        valid;
        logic        last;
        logic [47:0] lba;
        logic [15:0] data;
    } media_req_t;

endpackage : msw_pkg

// ---- msw_properties.sv ----
// concurrent checks on the ports of the multi-sector write block
module msw_properties
    import msw_pkg::*;
#(
    parameter int unsigned WORDS_PER_SECTOR = 256
) (
    // clock and reset
    input wire logic                clk_i,
    input wire logic                rst_i,
    // wishbone
    input wire logic                wb_cyc_i,
    input wire logic                wb_stb_i,
    input wire logic                wb_we_i,
    input wire logic [31:0]         wb_adr_i,
    input wire logic [31:0]         wb_dat_o,
    input wire logic                wb_ack_o,
    // media and interrupt
    input wire msw_pkg::media_req_t media_o,
    input wire logic                media_ready_i,
    input wire logic                media_error_i,
    input wire logic                irq_o
);
    // ======================================================================
    // word position inside the sector being sent
    logic [15:0] wcnt_q;
    logic [47:0] lba_q;
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wcnt_q <= 16'h0000;
            lba_q  <= 48'h0;
        end else if (media_o.valid && media_ready_i) begin
            wcnt_q <= media_o.last ? 16'h0000 : wcnt_q + 16'h0001;
            lba_q  <= media_o.lba;
        end
    end

    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);

    // ======================================================================
    // assertions
    chk_ack_one_cycle: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack held longer than one cycle");
    chk_ack_has_cause: assert property ($rose(wb_ack_o) |-> $past(wb_cyc_i && wb_stb_i))
        else $error("ack without request");
    chk_reg_ack_next: assert property ($rose(wb_cyc_i && wb_stb_i) && wb_adr_i[7:0] != OFF_DATA |=> wb_ack_o)
        else $error("register access not answered next cycle");
    chk_read_upper_zero: assert property (wb_ack_o && !wb_we_i |-> wb_dat_o[31:9] == 23'h0)
        else $error("read data upper bits not zero");
    chk_media_word_held: assert property (media_o.valid && !media_ready_i |=> media_o.valid && $stable(media_o))
        else $error("media word changed before taken");
    chk_last_word_place: assert property (media_o.valid |-> media_o.last == (wcnt_q == 16'(WORDS_PER_SECTOR - 1)))
        else $error("last marker not on final word of sector");
    chk_sector_lba_steady: assert property (media_o.valid && wcnt_q != 16'h0000 |-> media_o.lba == lba_q)
        else $error("sector address changed inside sector");
    chk_word_taken_once: assert property (media_o.valid && media_ready_i |=> !media_o.valid || media_o.data != $past(media_o.data))
        else $error("media word offered again after taken");

    cover property (media_o.valid && media_o.last && media_ready_i && media_error_i);
    cover property ($rose(irq_o));
    cover property (media_o.valid && !media_ready_i ##1 media_o.valid);
endmodule : msw_properties

bind multi_sector_write_command msw_properties #(.WORDS_PER_SECTOR(WORDS_PER_SECTOR)) msw_properties_i (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
    .wb_adr_i(wb_adr_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .media_o(media_o),
    .media_ready_i(media_ready_i), .media_error_i(media_error_i), .irq_o(irq_o));

// ---- multi_sector_write_command.sv ----
// block-mode multi-sector write command interpreter with wishbone task file
//
// Decided for this implementation: the Wishbone register port and the address map.

// Overview of operation
// - opcode C5 starts 28-bit block write
// - opcode 39 starts 48-bit two-deep write
// - accepted sectors are committed to media
// - one interrupt per block, not per sector
// - data moves as 16-bit words, with DRQ raised again for each sector
// - 28-bit count zero means 256 sectors
// - 48-bit count, address from current/previous bytes
// - CHS mode takes sector, cylinder, head
// - LBA mode assembles 28-bit address
// - final count holds sectors not transferred
// - CHS completion reports last transferred sector
// - LBA completion writes current address back
// - error reports failing 48-bit address, byte select
module multi_sector_write_command #(
    parameter int unsigned WORDS_PER_SECTOR  = 256,
    parameter int unsigned SECTORS_PER_TRACK = 63,
    parameter int unsigned HEADS             = 16
) (
    // clock and reset
    input  wire logic               clk_i,
    input  wire logic               rst_i,
    // wishbone slave
    input  wire logic               wb_cyc_i,
    input  wire logic               wb_stb_i,
    input  wire logic               wb_we_i,
    input  wire logic [31:0]        wb_adr_i,
    input  wire logic [3:0]         wb_sel_i,
    input  wire logic [31:0]        wb_dat_i,
    output logic      [31:0]        wb_dat_o,
    output logic                    wb_ack_o,
    // media write port
    output msw_pkg::media_req_t     media_o,
    input  wire logic               media_ready_i,
    input  wire logic               media_error_i,
    // interrupt
    output logic                    irq_o
);
    import msw_pkg::*;

    // ======================================================================
    // state
    typedef struct packed {
        phase_t      phase;
        logic [7:0]  sc_cur;
        logic [7:0]  sc_prev;
        logic [7:0]  sn_cur;
        logic [7:0]  sn_prev;
        logic [7:0]  cl_cur;
        logic [7:0]  cl_prev;
        logic [7:0]  ch_cur;
        logic [7:0]  ch_prev;
        logic [7:0]  dh;
        logic [7:0]  err;
        logic [7:0]  stat;
        logic        ext;
        logic        lba_mode;
        logic [16:0] remain;
        logic [47:0] addr;
        logic [15:0] words;
        logic [7:0]  blk;
        logic [7:0]  blk_size;
        logic        high_byte_readback_select;
        logic [1:0]  irq_stat;
        logic [1:0]  irq_mask;
        media_req_t  med;
        logic        ack;
        logic [31:0] rdat;
    } state_t;

    state_t q;
    state_t d;

    localparam logic [15:0] LAST_WORD = 16'(WORDS_PER_SECTOR - 1);
    localparam logic [7:0]  SPT       = 8'(SECTORS_PER_TRACK);
    localparam logic [3:0]  LAST_HEAD = 4'(HEADS - 1);

    // ======================================================================
    // helpers
    function automatic logic [7:0] pick_byte(input logic [7:0] cur, input logic [7:0] prev, input logic high_byte_readback_select);
        return high_byte_readback_select ? prev : cur;
    endfunction : pick_byte

    // address layout in 28-bit form is {head, cylinder, sector} either way
    function automatic logic [47:0] next_addr(input logic ext, input logic lba, input logic [47:0] a);
        logic [47:0] n;
        n = a + 48'h1;
        if (!ext && lba) begin
            n = {20'h00000, 28'(a[27:0] + 28'h1)};
        end else if (!ext) begin
            n = a;
            if (a[7:0] >= SPT) begin
                n[7:0] = 8'h01;
                if (a[27:24] >= LAST_HEAD) begin
                    n[27:24] = 4'h0;
                    n[23:8]  = 16'(a[23:8] + 16'h1);
                end else begin
                    n[27:24] = 4'(a[27:24] + 4'h1);
                end
            end else begin
                n[7:0] = 8'(a[7:0] + 8'h01);
            end
        end
        return n;
    endfunction : next_addr

    // ======================================================================
    // bus decode
    logic [7:0] bus_off;
    logic       req;
    logic       data_wr;
    logic       slot_free;
    logic       stall;
    logic       take;
    logic       med_take;

    assign bus_off   = wb_adr_i[7:0];
    assign req       = wb_cyc_i & wb_stb_i & ~q.ack;
    assign data_wr   = wb_we_i & (bus_off == OFF_DATA);
    assign slot_free = ~q.med.valid | media_ready_i;
    // data writes wait for the media slot, so a slow medium throttles the host
    assign stall     = data_wr & (q.phase == ST_XFER) & q.stat[DRQ_BIT] & ~slot_free;
    assign take      = req & ~stall;
    assign med_take  = q.med.valid & media_ready_i;

    // ======================================================================
    // next state
    always_comb begin
        logic [1:0]  irq_set;
        logic [1:0]  irq_clr;
        logic [15:0] cnt;
        logic        finish;
        logic        failed;
        irq_set = 2'b00;
        irq_clr = 2'b00;
        cnt     = 16'h0000;
        finish  = 1'b0;
        failed  = 1'b0;
        d       = q;
        d.ack   = take;
        if (med_take) begin
            d.med.valid = 1'b0;
        end

        if (take && !wb_we_i) begin
            d.rdat = 32'h00000000;
            case (bus_off)
                OFF_COUNT:    d.rdat[7:0] = pick_byte(q.sc_cur, q.sc_prev, q.high_byte_readback_select);
                OFF_SECTOR:   d.rdat[7:0] = pick_byte(q.sn_cur, q.sn_prev, q.high_byte_readback_select);
                OFF_CYL_LOW:  d.rdat[7:0] = pick_byte(q.cl_cur, q.cl_prev, q.high_byte_readback_select);
                OFF_CYL_HIGH: d.rdat[7:0] = pick_byte(q.ch_cur, q.ch_prev, q.high_byte_readback_select);
                OFF_DRV_HEAD: d.rdat[7:0] = q.dh;
                OFF_CMD_STAT: d.rdat[7:0] = q.stat;
                OFF_ERROR:    d.rdat[7:0] = q.err;
                OFF_IRQ_STAT: d.rdat[1:0] = q.irq_stat;
                OFF_IRQ_MASK: d.rdat[1:0] = q.irq_mask;
                OFF_CTRL:     d.rdat[8:0] = {q.high_byte_readback_select, q.blk_size};
                default:      d.rdat      = 32'h00000000;
            endcase
        end

        if (take && wb_we_i && wb_sel_i[0]) begin
            case (bus_off)
                OFF_DATA: begin
                    if (q.phase == ST_XFER && q.stat[DRQ_BIT]) begin
                        d.med.valid = 1'b1;
                        d.med.data  = wb_dat_i[15:0];
                        d.med.lba   = q.addr;
                        d.med.last  = (q.words == LAST_WORD);
                        d.words     = 16'(q.words + 16'h1);
                        if (q.words == LAST_WORD) begin
                            d.words              = 16'h0000;
                            d.phase              = ST_COMMIT;
                            d.stat[DRQ_BIT]      = 1'b0;
                            d.stat[BUSY_BIT]     = 1'b1;
                        end
                    end
                end
                // task file writes are ignored while a command runs
                OFF_COUNT: begin
                    if (q.phase == ST_IDLE) begin
                        d.sc_prev = q.sc_cur;
                        d.sc_cur  = wb_dat_i[7:0];
                    end
                end
                OFF_SECTOR: begin
                    if (q.phase == ST_IDLE) begin
                        d.sn_prev = q.sn_cur;
                        d.sn_cur  = wb_dat_i[7:0];
                    end
                end
                OFF_CYL_LOW: begin
                    if (q.phase == ST_IDLE) begin
                        d.cl_prev = q.cl_cur;
                        d.cl_cur  = wb_dat_i[7:0];
                    end
                end
                OFF_CYL_HIGH: begin
                    if (q.phase == ST_IDLE) begin
                        d.ch_prev = q.ch_cur;
                        d.ch_cur  = wb_dat_i[7:0];
                    end
                end
                OFF_DRV_HEAD: begin
                    if (q.phase == ST_IDLE) begin
                        d.dh = wb_dat_i[7:0];
                    end
                end
                OFF_CMD_STAT: begin
                    if (q.phase == ST_IDLE) begin
                        if (wb_dat_i[7:0] == OP_WRITE_BLOCK || wb_dat_i[7:0] == OP_WRITE_BLOCK_EXT) begin
                            d.ext      = (wb_dat_i[7:0] == OP_WRITE_BLOCK_EXT);
                            d.lba_mode = q.dh[DH_LBA_BIT];
                            if (d.ext) begin
                                cnt      = {q.sc_prev, q.sc_cur};
                                d.remain = (cnt == 16'h0000) ? CNT48_ZERO : {1'b0, cnt};
                                d.addr   = {q.ch_prev, q.cl_prev, q.sn_prev, q.ch_cur, q.cl_cur, q.sn_cur};
                            end else begin
                                cnt      = {8'h00, q.sc_cur};
                                d.remain = (cnt == 16'h0000) ? CNT28_ZERO : {1'b0, cnt};
                                d.addr   = {20'h00000, q.dh[3:0], q.ch_cur, q.cl_cur, q.sn_cur};
                            end
                            d.phase = ST_XFER;
                            d.words = 16'h0000;
                            d.blk   = 8'h00;
                            d.err   = 8'h00;
                            d.stat  = 8'h00;
                            d.stat[READY_BIT] = 1'b1;
                            d.stat[SEEK_BIT]  = 1'b1;
                            // first block is requested without an interrupt
                            d.stat[DRQ_BIT]   = 1'b1;
                        end else begin
                            d.err                = 8'h00;
                            d.err[ABORT_BIT]     = 1'b1;
                            d.stat               = 8'h00;
                            d.stat[READY_BIT]    = 1'b1;
                            d.stat[SEEK_BIT]     = 1'b1;
                            d.stat[STAT_ERR_BIT] = 1'b1;
                            irq_set[IRQ_DONE_BIT] = 1'b1;
                        end
                    end
                end
                OFF_IRQ_STAT: irq_clr    = wb_dat_i[1:0];
                OFF_IRQ_MASK: d.irq_mask = wb_dat_i[1:0];
                OFF_CTRL: begin
                    d.blk_size = wb_dat_i[7:0];
                    d.high_byte_readback_select      = wb_dat_i[CTRL_HOB_BIT];
                end
                default: ;
            endcase
        end

        // sector commit: the last word of a sector reaching the medium ends it
        if (q.phase == ST_COMMIT && med_take) begin
            if (media_error_i) begin
                finish = 1'b1;
                failed = 1'b1;
            end else begin
                d.remain = 17'(q.remain - 17'h1);
                if (q.remain == 17'h1) begin
                    finish = 1'b1;
                end else begin
                    d.addr             = next_addr(q.ext, q.lba_mode, q.addr);
                    d.phase            = ST_XFER;
                    d.stat[BUSY_BIT]   = 1'b0;
                    d.stat[DRQ_BIT]    = 1'b1;
                    d.blk              = 8'(q.blk + 8'h01);
                    if (8'(q.blk + 8'h01) >= q.blk_size) begin
                        d.blk                  = 8'h00;
                        irq_set[IRQ_BLOCK_BIT] = 1'b1;
                    end
                end
            end
        end

        // completion write-back; address stays on the last or failing sector
        if (finish) begin
            d.phase   = ST_IDLE;
            d.sc_cur  = d.remain[7:0];
            d.sc_prev = d.remain[15:8];
            d.sn_cur  = q.addr[7:0];
            d.cl_cur  = q.addr[15:8];
            d.ch_cur  = q.addr[23:16];
            if (q.ext) begin
                d.sn_prev = q.addr[31:24];
                d.cl_prev = q.addr[39:32];
                d.ch_prev = q.addr[47:40];
            end else begin
                d.dh[3:0] = q.addr[27:24];
            end
            d.err                  = 8'h00;
            d.err[IDNF_BIT]        = failed;
            d.stat                 = 8'h00;
            d.stat[READY_BIT]      = 1'b1;
            d.stat[SEEK_BIT]       = 1'b1;
            d.stat[STAT_ERR_BIT]   = failed;
            irq_set[IRQ_DONE_BIT]  = 1'b1;
        end

        // a new event beats a clear in the same cycle
        d.irq_stat = (q.irq_stat & ~irq_clr) | irq_set;
    end

    // ======================================================================
    // registers
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            q          <= '0;
            q.phase    <= ST_IDLE;
            q.stat     <= STAT_RESET;
            q.blk_size <= BLK_RESET;
        end else begin
            q <= d;
        end
    end

    // ======================================================================
    // outputs
    assign wb_dat_o = q.rdat;
    assign wb_ack_o = q.ack;
    assign media_o  = q.med;
    assign irq_o    = |(q.irq_stat & q.irq_mask);

endmodule : multi_sector_write_command

// ---- multi_sector_write_command_test.sv ----
// self-checking bench for the multi-sector write block
module multi_sector_write_command_test;
    timeunit 1ns;
    timeprecision 1ps;
    import msw_pkg::*;
    localparam int unsigned WPS = 4;
    logic        clk_i = 1'b0, rst_i = 1'b1, wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
    logic [31:0] wb_adr_i = 32'h0, wb_dat_i = 32'h0, wb_dat_o, rd;
    logic        wb_ack_o, media_ready_i, media_error_i, irq_o, slow = 1'b1, fail_en = 1'b0;
    logic [47:0] fail_lba = 48'h0;
    media_req_t  media_o;
    int          err_count = 0, cmp_count = 0, cyc_n = 0;

    always #12.5 clk_i = !clk_i;

    multi_sector_write_command #(.WORDS_PER_SECTOR(WPS)) multi_sector_write_command_i (
        .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
        .wb_adr_i(wb_adr_i), .wb_sel_i(4'hF), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
        .media_o(media_o), .media_ready_i(media_ready_i), .media_error_i(media_error_i), .irq_o(irq_o));
    media_model media_model_i (.clk_i(clk_i), .rst_i(rst_i), .media_i(media_o), .ready_o(media_ready_i),
        .error_o(media_error_i), .slow_i(slow), .fail_en_i(fail_en), .fail_lba_i(fail_lba));

    // ======================================================================
    // reporting
    task automatic report_and_stop();
        $display("comparisons %0d mismatches %0d", cmp_count, err_count);
        if (err_count == 0 && cmp_count > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : report_and_stop

    task automatic chk_reg(input string nm, input logic [31:0] e, input logic [31:0] g);
        cmp_count++;
        if (g !== e) begin
            err_count++;
            $display("MISMATCH %s expected %h seen %h", nm, e, g);
        end
    endtask : chk_reg

    task automatic chk_lba(input string nm, input logic [47:0] e, input logic [47:0] g);
        cmp_count++;
        if (g !== e) begin
            err_count++;
            $display("MISMATCH %s expected %h seen %h", nm, e, g);
        end
    endtask : chk_lba

    // ======================================================================
    // wishbone classic access, held until ack is sampled
    task automatic wb_acc(input logic w, input logic [7:0] a, input logic [15:0] d);
        @(posedge clk_i);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i  <= w;
        wb_adr_i <= {24'h000000, a};
        wb_dat_i <= {16'h0000, d};
        // no local limit: only the cycle ceiling below ends a hung wait
        do begin
            @(posedge clk_i);
        end while (wb_ack_o !== 1'b1);
        rd = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        wb_we_i  <= 1'b0;
    endtask : wb_acc

    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        wb_acc(1'b1, a, d);
    endtask : wr

    task automatic rdchk(input string nm, input logic [7:0] a, input logic [31:0] e);
        wb_acc(1'b0, a, 16'h0000);
        chk_reg(nm, e, rd);
    endtask : rdchk

    // poll status until not busy and data request equals drq
    task automatic wait_st(input logic data_request_flag);
        do begin
            wb_acc(1'b0, OFF_CMD_STAT, 16'h0000);
        end while (rd[BUSY_BIT] !== 1'b0 || rd[DRQ_BIT] !== data_request_flag);
    endtask : wait_st

    task automatic send_sector(input logic [7:0] s);
        wait_st(1'b1);
        for (int w = 0; w < WPS; w++) wr(OFF_DATA, {s, 8'(w)});
    endtask : send_sector

    task automatic do_reset();
        rst_i <= 1'b1;
        repeat (4) @(posedge clk_i);
        rst_i <= 1'b0;
    endtask : do_reset

    always @(posedge clk_i) begin
        cyc_n++;
        if (cyc_n == 40000) begin
            err_count++;
            report_and_stop();
        end
    end

    // ======================================================================
    // scenarios
    initial begin
        do_reset();
        rdchk("status", OFF_CMD_STAT, 32'h50);
        rdchk("error", OFF_ERROR, 32'h0);
        // 28-bit logical address, blocks of two sectors, stalling medium
        wr(OFF_CTRL, 16'h0002);
        wr(OFF_IRQ_MASK, 16'h0003);
        wr(OFF_COUNT, 16'h0003);
        wr(OFF_SECTOR, 16'h0056);
        wr(OFF_CYL_LOW, 16'h0034);
        wr(OFF_CYL_HIGH, 16'h0012);
        wr(OFF_DRV_HEAD, 16'h00EA);
        wr(OFF_CMD_STAT, 16'h00C5);
        send_sector(8'h00);
        wait_st(1'b1);
        chk_reg("irq", 32'h0, {31'h0, irq_o});
        send_sector(8'h01);
        wait_st(1'b1);
        chk_reg("irq", 32'h1, {31'h0, irq_o});
        rdchk("irq status", OFF_IRQ_STAT, 32'h1);
        wr(OFF_IRQ_STAT, 16'h0001);
        chk_reg("irq", 32'h0, {31'h0, irq_o});
        send_sector(8'h02);
        wait_st(1'b0);
        rdchk("status", OFF_CMD_STAT, 32'h50);
        rdchk("count", OFF_COUNT, 32'h0);
        rdchk("sector", OFF_SECTOR, 32'h58);
        rdchk("cyl low", OFF_CYL_LOW, 32'h34);
        rdchk("cyl high", OFF_CYL_HIGH, 32'h12);
        wb_acc(1'b0, OFF_DRV_HEAD, 16'h0000);
        chk_reg("head", 32'hA, {28'h0, rd[3:0]});
        rdchk("irq status", OFF_IRQ_STAT, 32'h2);
        chk_reg("sectors", 32'h3, 32'(media_model_i.lba_q.size()));
        chk_lba("last lba", 48'h00000A123458, media_model_i.lba_q[2]);
        for (int i = 0; i < 3 * WPS; i++) chk_reg("word", {16'h0, 8'(i / WPS), 8'(i % WPS)}, {16'h0, media_model_i.words_q[i]});
        // 48-bit write, second sector fails, interrupt masked
        do_reset();
        slow <= 1'b0;
        fail_en <= 1'b1;
        fail_lba <= 48'h332211665545;
        wr(OFF_COUNT, 16'h0000);
        wr(OFF_COUNT, 16'h0002);
        wr(OFF_SECTOR, 16'h0011);
        wr(OFF_SECTOR, 16'h0044);
        wr(OFF_CYL_LOW, 16'h0022);
        wr(OFF_CYL_LOW, 16'h0055);
        wr(OFF_CYL_HIGH, 16'h0033);
        wr(OFF_CYL_HIGH, 16'h0066);
        wr(OFF_DRV_HEAD, 16'h0040);
        wr(OFF_CMD_STAT, 16'h0039);
        send_sector(8'h00);
        send_sector(8'h01);
        wait_st(1'b0);
        chk_lba("first lba", 48'h332211665544, media_model_i.lba_q[0]);
        rdchk("status", OFF_CMD_STAT, 32'h51);
        rdchk("error", OFF_ERROR, 32'h10);
        rdchk("count", OFF_COUNT, 32'h01);
        rdchk("sector", OFF_SECTOR, 32'h45);
        rdchk("cyl low", OFF_CYL_LOW, 32'h55);
        rdchk("cyl high", OFF_CYL_HIGH, 32'h66);
        wr(OFF_CTRL, 16'h0101);
        rdchk("sector hob", OFF_SECTOR, 32'h11);
        rdchk("cyl low hob", OFF_CYL_LOW, 32'h22);
        rdchk("cyl high hob", OFF_CYL_HIGH, 32'h33);
        rdchk("irq status", OFF_IRQ_STAT, 32'h3);
        chk_reg("irq masked", 32'h0, {31'h0, irq_o});
        // 28-bit head/cylinder/sector from the last sector of a track, count zero runs 256 sectors
        do_reset();
        slow <= 1'b1;
        fail_en <= 1'b0;
        wr(OFF_COUNT, 16'h0000);
        wr(OFF_SECTOR, 16'h003F);
        wr(OFF_CYL_LOW, 16'h0002);
        wr(OFF_CYL_HIGH, 16'h0001);
        wr(OFF_DRV_HEAD, 16'h00A3);
        wr(OFF_CMD_STAT, 16'h00C5);
        send_sector(8'h00);
        wait_st(1'b1);
        chk_reg("drq after one", 32'h1, {31'h0, rd[DRQ_BIT]});
        for (int s = 1; s < 256; s++) send_sector(8'(s));
        wait_st(1'b0);
        chk_reg("chs sectors", 32'h100, 32'(media_model_i.lba_q.size()));
        chk_lba("chs lba", 48'h00000301023F, media_model_i.lba_q[0]);
        chk_lba("chs next", 48'h000004010201, media_model_i.lba_q[1]);
        rdchk("count", OFF_COUNT, 32'h0);
        rdchk("sector", OFF_SECTOR, 32'h03);
        rdchk("cyl low", OFF_CYL_LOW, 32'h02);
        rdchk("cyl high", OFF_CYL_HIGH, 32'h01);
        wb_acc(1'b0, OFF_DRV_HEAD, 16'h0000);
        chk_reg("head", 32'h8, {28'h0, rd[3:0]});
        // unknown opcode and unmapped address
        do_reset();
        wr(OFF_CMD_STAT, 16'h00A7);
        rdchk("status", OFF_CMD_STAT, 32'h51);
        rdchk("error", OFF_ERROR, 32'h04);
        rdchk("unmapped", 8'h40, 32'h0);
        report_and_stop();
    end
endmodule : multi_sector_write_command_test
